// ---- vfd_scan_driver.sv ----
// Purpose: automatic scan driver for a fluorescent tube, apb slave on top
// Assumes: run_mode_normal comes from power control logic on pclk
// Notes:   zero wait state apb when ce is high; ce low freezes everything
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vfd_scan_driver (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic run_mode_normal,
   output logic [36:0] hv_out,
   output logic [36:0] hv_scan_sel,
   output logic scan_idle
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // outputs 0..n-1 belong to the scanner; reserved codes fall back to 32
   function automatic logic [36:0] out_mask(input logic [4:0] sel);
      logic [5:0] n;
      logic [37:0] m;
      n = vfd_pkg::VFD_MIN_OUT;
      if (sel <= vfd_pkg::VFD_MAX_COUNT_SEL) begin
         n = vfd_pkg::VFD_MIN_OUT + {1'b0, sel};
      end
      m = (38'h1 << n) - 38'h1;
      return m[36:0];
   endfunction : out_mask

   // active steps out of sixteen; reserved code 0 behaves like code 1
   function automatic logic [4:0] active_steps(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel == 3'h0) ? 3'h1 : sel;
      return vfd_pkg::VFD_PHASE_STEPS - {1'b0, s, 1'b0};
   endfunction : active_steps

   vfd_pkg::vfd_ctrl1_t ctrl1_q;
   vfd_pkg::vfd_ctrl2_t ctrl2_q;
   logic [7:0] ctrl3_q;
   vfd_pkg::vfd_state_t state_q;
   logic [3:0] slot_q;
   logic mode_q;
   logic cap_q;
   logic [31:0] prdata_q;
   logic [36:0] hv_out_q;
   logic [36:0] sel_q;
   logic [13:0] word_w;
   logic [13:0] buf_off_w;
   logic is_buf_w;
   logic mapped_w;
   logic [31:0] rd_word_w;
   logic access_w;
   logic wr_w;
   logic wr_ctrl1_w;
   logic mode_drop_w;
   logic slot_end;
   logic [3:0] phase;
   logic active_w;
   logic [3:0] last_slot_w;
   logic [7:0] buf_rd_w;
   logic [39:0] row_w;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // data is captured on the setup edge so prdata comes from a flop
   assign word_w = paddr[15:2];
   assign buf_off_w = word_w - vfd_pkg::VFD_IDX_BUF_BASE;
   assign is_buf_w = (word_w >= vfd_pkg::VFD_IDX_BUF_BASE)
                   && (buf_off_w < vfd_pkg::VFD_BUF_BYTES);
   assign access_w = ce && psel && penable && cap_q;
   assign pready = access_w;
   assign pslverr = access_w && !mapped_w;
   assign prdata = prdata_q;
   assign wr_w = access_w && pwrite && pstrb[0] && mapped_w;
   assign wr_ctrl1_w = wr_w && (word_w == vfd_pkg::VFD_IDX_CTRL1);

   // read mux and address check
   always_comb begin
      rd_word_w = 32'h0000_0000;
      mapped_w = 1'b1;
      if (paddr[1:0] != 2'b00) begin
         mapped_w = 1'b0;
      end else if (word_w == vfd_pkg::VFD_IDX_CTRL1) begin
         rd_word_w[7:0] = ctrl1_q;
      end else if (word_w == vfd_pkg::VFD_IDX_CTRL2) begin
         rd_word_w[7:0] = ctrl2_q;
      end else if (word_w == vfd_pkg::VFD_IDX_CTRL3) begin
         rd_word_w[7:0] = ctrl3_q;
      end else if (word_w == vfd_pkg::VFD_IDX_STATUS) begin
         rd_word_w[vfd_pkg::VFD_STATUS_IDLE_BIT] = scan_idle;
      end else if (is_buf_w) begin
         rd_word_w[7:0] = buf_rd_w;
         // the fifth column only holds outputs 32..36
         if (buf_off_w[6:0] >= vfd_pkg::VFD_BUF_LAST_COL) begin
            rd_word_w[7:0] = buf_rd_w & vfd_pkg::VFD_LAST_COL_MASK;
         end
      end else begin
         mapped_w = 1'b0;
      end
   end

   // transfer tracker and read data capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         if (!psel || access_w) begin
            cap_q <= 1'b0;
         end else if (!cap_q) begin
            cap_q <= 1'b1;
            prdata_q <= rd_word_w;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   assign mode_drop_w = mode_q && !run_mode_normal;

   // forced blank wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_q <= vfd_pkg::VFD_CTRL1_RST;
         ctrl2_q <= vfd_pkg::VFD_CTRL2_RST;
         ctrl3_q <= vfd_pkg::VFD_CTRL3_RST;
         mode_q <= 1'b1;
      end else if (ce) begin
         mode_q <= run_mode_normal;
         if (wr_ctrl1_w) begin
            ctrl1_q <= vfd_pkg::vfd_ctrl1_t'(pwdata[7:0]);
         end
         if (mode_drop_w) begin
            ctrl1_q.blank <= 1'b1;
         end
         if (wr_w && word_w == vfd_pkg::VFD_IDX_CTRL2) begin
            ctrl2_q <= vfd_pkg::vfd_ctrl2_t'(pwdata[7:0]);
         end
         if (wr_w && word_w == vfd_pkg::VFD_IDX_CTRL3) begin
            ctrl3_q <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // slot timing and buffer
   // ----------------------------------------------------------------
   vfd_slot_timer #(
      .CNT_W(12)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .slot_period_sel(ctrl1_q.slot_period_sel),
      .slot_period_halve(ctrl3_q[vfd_pkg::VFD_CTRL3_HALVE_BIT]),
      .slot_end(slot_end),
      .phase(phase)
   );

   vfd_disp_buffer #(
      .DEPTH(80),
      .ROWS(16)
   ) u_buffer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .wr_en(wr_w && is_buf_w),
      .wr_addr(buf_off_w[6:0]),
      .wr_data(pwdata[7:0]),
      .rd_addr(buf_off_w[6:0]),
      .rd_data(buf_rd_w),
      .slot(slot_q),
      .row(row_w)
   );

   // reserved state counts clamp to sixteen slots
   assign last_slot_w = (ctrl2_q.state_count_sel > vfd_pkg::VFD_MAX_STATE_SEL)
                      ? 4'hF : ctrl2_q.state_count_sel[3:0];
   assign active_w = ({1'b0, phase} < active_steps(ctrl2_q.dimmer_sel));

   // ----------------------------------------------------------------
   // scan sequencer
   // ----------------------------------------------------------------
   // outside a drop from normal mode the state changes only at slot ends, so no half slot is shown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= vfd_pkg::VFD_ST_IDLE;
         slot_q <= 4'h0;
      end else if (ce) begin
         if (!run_mode_normal) begin
            state_q <= vfd_pkg::VFD_ST_IDLE;
            slot_q <= 4'h0;
         end else begin
            case (state_q)
               vfd_pkg::VFD_ST_IDLE: begin
                  if (slot_end && !ctrl1_q.blank) begin
                     state_q <= vfd_pkg::VFD_ST_ARM;
                  end
               end
               vfd_pkg::VFD_ST_ARM: begin
                  if (slot_end) begin
                     state_q <= ctrl1_q.blank ? vfd_pkg::VFD_ST_IDLE
                                              : vfd_pkg::VFD_ST_DRIVE;
                     slot_q <= 4'h0;
                  end
               end
               vfd_pkg::VFD_ST_DRIVE: begin
                  if (slot_end && ctrl1_q.blank) begin
                     state_q <= vfd_pkg::VFD_ST_IDLE;
                     slot_q <= 4'h0;
                  end else if (slot_end) begin
                     slot_q <= (slot_q >= last_slot_w) ? 4'h0
                                                       : slot_q + 4'h1;
                  end
               end
               default: begin
                  state_q <= vfd_pkg::VFD_ST_IDLE;
               end
            endcase
         end
      end
   end

   assign scan_idle = (state_q == vfd_pkg::VFD_ST_IDLE);

   // ----------------------------------------------------------------
   // high-voltage outputs
   // ----------------------------------------------------------------
   // any bit may be grid or segment: the row is only masked by the output count and gated by the drive state, normal mode and the dimmer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hv_out_q <= '0;
         sel_q <= '0;
      end else if (ce) begin
         sel_q <= out_mask(ctrl1_q.output_count_sel);
         if (run_mode_normal && state_q == vfd_pkg::VFD_ST_DRIVE && active_w) begin
            hv_out_q <= row_w[36:0] & out_mask(ctrl1_q.output_count_sel);
         end else begin
            hv_out_q <= '0;
         end
      end
   end

   assign hv_out = hv_out_q;
   assign hv_scan_sel = sel_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking vfd_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_drive_end_blank;
      ce && run_mode_normal && state_q == vfd_pkg::VFD_ST_DRIVE
         && slot_end && ctrl1_q.blank;
   endsequence

   sequence s_drive_end_go;
      ce && run_mode_normal && state_q == vfd_pkg::VFD_ST_DRIVE
         && slot_end && !ctrl1_q.blank;
   endsequence

   AST_BLANK_STOPS: assert property (
      s_drive_end_blank |=> scan_idle)
      else $error("blank at slot end did not stop the scan");
   AST_BLANK_OUT_LOW: assert property (
      s_drive_end_blank ##1 ce |=> hv_out == '0)
      else $error("outputs still driven after blanking");
   AST_UNBLANK_CLEAR_IDLE: assert property (
      ce && run_mode_normal && scan_idle && slot_end && !ctrl1_q.blank
         |=> !scan_idle && state_q == vfd_pkg::VFD_ST_ARM)
      else $error("idle flag not cleared at slot end");
   AST_ARM_TO_DRIVE: assert property (
      ce && run_mode_normal && state_q == vfd_pkg::VFD_ST_ARM && slot_end
         && !ctrl1_q.blank |=> state_q == vfd_pkg::VFD_ST_DRIVE && slot_q == 4'h0)
      else $error("driving did not start one slot after unblank");
   AST_NO_DRIVE_OFF: assert property (
      ce && state_q != vfd_pkg::VFD_ST_DRIVE |=> hv_out == '0)
      else $error("outputs driven while not scanning");
   AST_MODE_DROP: assert property (
      ce && mode_drop_w |=> ctrl1_q.blank && scan_idle && hv_out == '0)
      else $error("leaving normal mode did not blank the display");
   AST_MODE_KEEP: assert property (
      ce && mode_drop_w && !wr_ctrl1_w
         |=> $stable(ctrl1_q.slot_period_sel) && $stable(ctrl1_q.output_count_sel))
      else $error("control fields lost on mode change");
   AST_SLOT_STEP: assert property (
      s_drive_end_go ##0 (slot_q < last_slot_w) |=> slot_q == $past(slot_q) + 4'h1)
      else $error("slot index did not advance");
   AST_SLOT_WRAP: assert property (
      s_drive_end_go ##0 (slot_q >= last_slot_w) |=> slot_q == 4'h0)
      else $error("slot index did not wrap after last slot");
   AST_UNSEL_LOW: assert property (
      (hv_out & ~hv_scan_sel) == '0)
      else $error("unselected output driven by the scanner");
   AST_DIMMER_GATE: assert property (
      ce && state_q == vfd_pkg::VFD_ST_DRIVE && !active_w |=> hv_out == '0)
      else $error("output driven outside the active fraction");

endmodule : vfd_scan_driver
`default_nettype wire

// ---- vfd_pkg.sv ----
// Purpose: shared constants and types for the fluorescent display scan driver
// Assumes: apb word access, register index times four gives the byte address
// Notes:   field layouts are packed structs matching the register bit order
package vfd_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [13:0] VFD_IDX_CTRL1 = 14'h002A;
   localparam logic [13:0] VFD_IDX_CTRL2 = 14'h002B;
   localparam logic [13:0] VFD_IDX_CTRL3 = 14'h002C;
   localparam logic [13:0] VFD_IDX_STATUS = 14'h002D;
   localparam logic [13:0] VFD_IDX_BUF_BASE = 14'h0F80;
   localparam logic [13:0] VFD_BUF_BYTES = 14'h0050;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] VFD_CTRL1_RST = 8'h80;
   localparam logic [7:0] VFD_CTRL2_RST = 8'h20;
   localparam logic [7:0] VFD_CTRL3_RST = 8'h00;
   localparam int VFD_STATUS_IDLE_BIT = 7;
   localparam int VFD_CTRL3_HALVE_BIT = 0;
   localparam logic [6:0] VFD_BUF_LAST_COL = 7'h40;
   localparam logic [7:0] VFD_LAST_COL_MASK = 8'h1F;

   // ----------------------------------------------------------------
   // scan geometry and timing counts
   // ----------------------------------------------------------------
   localparam int VFD_NUM_OUT = 37;
   localparam logic [5:0] VFD_MIN_OUT = 6'h20;
   localparam logic [4:0] VFD_MAX_COUNT_SEL = 5'h05;
   localparam logic [4:0] VFD_MAX_STATE_SEL = 5'h0F;
   localparam logic [3:0] VFD_PERIOD_EXP_BASE = 4'h9;
   localparam logic [3:0] VFD_PHASE_BITS = 4'h4;
   localparam logic [4:0] VFD_PHASE_STEPS = 5'h10;

   typedef struct packed {
      logic blank;
      logic [1:0] slot_period_sel;
      logic [4:0] output_count_sel;
   } vfd_ctrl1_t;

   typedef struct packed {
      logic [2:0] dimmer_sel;
      logic [4:0] state_count_sel;
   } vfd_ctrl2_t;

   typedef enum logic [1:0] {
      VFD_ST_IDLE = 2'b00,
      VFD_ST_ARM = 2'b01,
      VFD_ST_DRIVE = 2'b10
   } vfd_state_t;

endpackage : vfd_pkg

// ---- vfd_slot_timer.sv ----
// Purpose: free running slot period counter with a sixteen step phase
// Assumes: period settings only change while the display is blanked
// Notes:   slot_end is a one-cycle pulse on the last cycle of each period
`timescale 1ns/1ps
`default_nettype none
module vfd_slot_timer #(
   parameter int CNT_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [1:0] slot_period_sel,
   input wire logic slot_period_halve,
   output logic slot_end,
   output logic [3:0] phase
);

   logic [CNT_W-1:0] cnt_q;
   logic [3:0] exp_w;
   logic [CNT_W:0] last_w;

   // ----------------------------------------------------------------
   // period of 2^exp cycles, exp from 8 to 12
   // ----------------------------------------------------------------
   always_comb begin
      exp_w = vfd_pkg::VFD_PERIOD_EXP_BASE + {2'b00, slot_period_sel}
            - {3'b000, slot_period_halve};
      last_w = ((CNT_W+1)'(1) << exp_w) - (CNT_W+1)'(1);
      // >= so a shortened period never lets the count run away
      slot_end = ({1'b0, cnt_q} >= last_w);
      phase = 4'(cnt_q >> (exp_w - vfd_pkg::VFD_PHASE_BITS));
   end

   // counter wraps at the end of each slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (ce) begin
         cnt_q <= slot_end ? '0 : cnt_q + CNT_W'(1);
      end
   end

endmodule : vfd_slot_timer
`default_nettype wire

// ---- vfd_disp_buffer.sv ----
// Purpose: 80-byte display buffer, 16 rows by five byte columns
// Assumes: byte n sits at column n/16, timing slot n%16
// Notes:   cleared at reset so the tube never shows stale pixels
`timescale 1ns/1ps
`default_nettype none
module vfd_disp_buffer #(
   parameter int DEPTH = 80,
   parameter int ROWS = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic [3:0] slot,
   output logic [8*(DEPTH/ROWS)-1:0] row
);

   logic [7:0] mem_q [DEPTH];

   // ----------------------------------------------------------------
   // software write port
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (ce && wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // read ports: one byte for software, one whole row for the scanner
   always_comb begin
      rd_data = mem_q[rd_addr];
      for (int c = 0; c < DEPTH/ROWS; c++) begin
         row[c*8 +: 8] = mem_q[c*ROWS + int'(slot)];
      end
   end

endmodule : vfd_disp_buffer
`default_nettype wire

// ---- vfd_tube_model.sv ----
// Purpose: behavioural tube electrodes seen from the scan driver outputs
// Assumes: every rising pclk edge is one sample of the grid and segment levels
// Notes:   counts lit cycles, gathers every lit electrode, flags stray drive
`timescale 1ns/1ps
`default_nettype none
module vfd_tube_model (
   input wire logic pclk,
   input wire logic clr,
   input wire logic [36:0] hv_out,
   input wire logic [36:0] hv_scan_sel,
   output int lit_cycles,
   output logic [36:0] glow_or,
   output logic stray
);
   // ----------------------------------------------------------------
   // glow accounting
   // ----------------------------------------------------------------
   // a lit pin outside the scanner mask would fight a general-purpose port
   always_ff @(posedge pclk) begin
      if (clr) begin
         lit_cycles <= 0;
         glow_or <= 37'h0;
         stray <= 1'b0;
      end else begin
         if (hv_out != 37'h0) lit_cycles <= lit_cycles + 1;
         glow_or <= glow_or | hv_out;
         if ((hv_out & ~hv_scan_sel) != 37'h0) stray <= 1'b1;
      end
   end
endmodule : vfd_tube_model
`default_nettype wire

// ---- fluorescent_display_scan_driver_tb_top.sv ----
// Purpose: self-checking bench for the fluorescent display scan driver
// Assumes: zero wait apb answers, but the master waits for pready anyway
// Notes:   256-cycle slots with two slots keep the run short
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   cmp_count++; \
   if ((got) !== (ex)) begin \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
      failures++; \
   end
module fluorescent_display_scan_driver_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err, run_mode_normal = 1'b1, scan_idle, clr = 1'b1, stray;
   logic [36:0] hv_out, hv_scan_sel, glow_or;
   int lit_cycles, failures = 0, cmp_count = 0;
   // dimmer code beside expected lit cycles over two 256-cycle slots
   logic [2:0] dim_tab [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
   int lit_tab [8] = '{448, 384, 320, 256, 192, 128, 64, 448};
   // ----------------------------------------------------------------
   // clock, design and tube
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   vfd_scan_driver DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .run_mode_normal(run_mode_normal), .hv_out(hv_out), .hv_scan_sel(hv_scan_sel),
      .scan_idle(scan_idle));
   vfd_tube_model tube (.pclk(pclk), .clr(clr), .hv_out(hv_out),
      .hv_scan_sel(hv_scan_sel), .lit_cycles(lit_cycles), .glow_or(glow_or),
      .stray(stray));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // pready, prdata and pslverr are taken at the same rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // bounded wait: 0 idle high, 1 idle low, 2 some output lit
   task automatic wait_for(input int what, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (!((what == 0 && scan_idle === 1'b1) || (what == 1 && scan_idle === 1'b0)
         || (what == 2 && hv_out !== 37'h0)) && n < lim);
      if (n >= lim) begin
         failures++;
         report_and_stop();
      end
   endtask : wait_for
   // lit cycles seen by the tube over cyc edges
   task automatic glow_count(input int cyc);
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (cyc) @(posedge pclk);
      @(negedge pclk);
   endtask : glow_count
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // the releasing edge still sees reset; the scanner mask loads one edge later
      repeat (2) @(negedge pclk);
      `CHK("idle_rst", 1'b1, scan_idle)
      `CHK("sel_rst", 37'h0_FFFF_FFFF, hv_scan_sel)
      apb(1'b0, 16'h00A8, 8'h00);
      `CHK("ctrl1_rst", 32'h0000_0080, rd)
      apb(1'b0, 16'h00AC, 8'h00);
      `CHK("ctrl2_rst", 32'h0000_0020, rd)
      apb(1'b0, 16'h00B4, 8'h00);
      `CHK("status_rst", 32'h0000_0080, rd)
      apb(1'b0, 16'h0004, 8'h00);
      `CHK("unmapped_err", 1'b1, err)
      // buffer data first, blank still set
      apb(1'b1, 16'h3E00, 8'h01);
      apb(1'b1, 16'h3E80, 8'hA5);
      apb(1'b1, 16'h3F00, 8'h1F);
      apb(1'b1, 16'h3E04, 8'h02);
      apb(1'b1, 16'h3EC4, 8'h3C);
      apb(1'b1, 16'h3E48, 8'h80);
      apb(1'b1, 16'h00AC, 8'h21);
      apb(1'b1, 16'h00B0, 8'h01);
      apb(1'b1, 16'h00A8, 8'h85);
      apb(1'b1, 16'h00A8, 8'h05);
      wait_for(1, 600);
      glow_count(200);
      `CHK("arm_dark", 0, lit_cycles)
      wait_for(2, 100);
      `CHK("sel_37", 37'h1F_FFFF_FFFF, hv_scan_sel)
      glow_count(512);
      `CHK("rows", 37'h1F_3CA5_0003, glow_or)
      `CHK("stray", 1'b0, stray)
      apb(1'b0, 16'h00B4, 8'h00);
      `CHK("status_run", 32'h0000_0000, rd)
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 16'h00AC, {dim_tab[i], 5'h01});
         repeat (512) @(posedge pclk);
         glow_count(512);
         `CHK("dim_lit", lit_tab[i], lit_cycles)
      end
      apb(1'b1, 16'h00A8, 8'h85);
      wait_for(0, 300);
      @(negedge pclk);
      `CHK("blank_dark", 37'h0, hv_out)
      apb(1'b0, 16'h00B4, 8'h00);
      `CHK("status_blank", 32'h0000_0080, rd)
      apb(1'b1, 16'h00A8, 8'h05);
      wait_for(2, 1200);
      @(posedge pclk);
      run_mode_normal <= 1'b0;
      repeat (2) @(negedge pclk);
      `CHK("slow_idle", 1'b1, scan_idle)
      `CHK("slow_dark", 37'h0, hv_out)
      apb(1'b0, 16'h00A8, 8'h00);
      `CHK("slow_ctrl1", 32'h0000_0085, rd)
      @(posedge pclk);
      run_mode_normal <= 1'b1;
      apb(1'b1, 16'h00A8, 8'h80);
      repeat (3) @(negedge pclk);
      `CHK("sel_32", 37'h0_FFFF_FFFF, hv_scan_sel)
      report_and_stop();
   end
endmodule : fluorescent_display_scan_driver_tb_top
`default_nettype wire
